// File: common/nslp_pkg.sv
// Function
// R1 - Flash self-write instruction only programs when fetched from the boot section
// R2 - Self-write from boot may address any flash location, boot section included
// R3 - Flash locations are sixteen bits; instructions use one or two locations
// R4 - Application table equals boot section in size and has its own lock field
// R5 - Separate lock fields block read, write or both per flash section
// R6 - Programmer and software may write locks, but only toward stricter protection
// R7 - Locks clear only by chip erase, after all other flash is erased; the core also reloads erased locks at every reset
// R8 - Unprogrammed fuse or lock bit reads one, programmed reads zero
// R9 - Only the programmer writes fuses; software may only read them
// R10 - Factory signature row rejects all writes and erases but stays readable
// R11 - Part of the factory calibration is copied out automatically after reset
// R12 - User signature row is one page, survives chip erase, has own erase
// R13 - Programmer should write every fuse byte to a valid setting
// R14 - Flash is reachable from both the programmer port and software
// R15 - Register space, EEPROM and SRAM have fixed data-space start addresses
// R16 - Internal SRAM always starts at the same fixed data-space address
// R17 - Accesses forbidden by the current lock setting are silently ignored
package nslp_pkg;
    localparam int          WORD_W      = 16;              // Flash location width
    localparam int          FUSE_BYTES  = 4;
    localparam int          CAL_AUTO    = 2;               // Words loaded after reset
    localparam logic [15:0] BOOT_START  = 16'hf000;
    localparam logic [15:0] BOOT_WORDS  = 16'h1000;
    localparam logic [15:0] TABLE_START = 16'(BOOT_START - BOOT_WORDS);
    localparam logic [23:0] DS_EEP_BASE  = 24'h001000;
    localparam logic [23:0] DS_SRAM_BASE = 24'h002000;
    localparam logic [7:0]  REG_ADDR    = 8'h00;
    localparam logic [7:0]  REG_DATA    = 8'h04;
    localparam logic [7:0]  REG_CMD     = 8'h08;
    localparam logic [7:0]  REG_STATUS  = 8'h0c;
    localparam logic [7:0]  REG_LOCK    = 8'h10;
    localparam logic [7:0]  REG_FUSE    = 8'h14;
    localparam logic [7:0]  LOCK_RST    = 8'hff;           // Erased state is all ones
    localparam logic [7:0]  FUSE_RST    = 8'hff;
    localparam int          LK_APP_LSB  = 0;
    localparam int          LK_TBL_LSB  = 2;
    localparam int          LK_BOOT_LSB = 4;
    localparam int          LK_WR_BIT   = 0;               // One means writes allowed
    localparam int          LK_RD_BIT   = 1;               // One means reads allowed
    localparam int          ST_BUSY     = 0;
    localparam int          ST_DENY     = 1;
    localparam int          ST_PEND     = 2;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        NSLP_RD_FLASH = 4'h0, NSLP_WR_FLASH = 4'h1, NSLP_ER_PAGE  = 4'h2,
        NSLP_CHIP_ER  = 4'h3, NSLP_RD_USIG  = 4'h4, NSLP_WR_USIG  = 4'h5,
        NSLP_ER_USIG  = 4'h6, NSLP_RD_PSIG  = 4'h7, NSLP_WR_PSIG  = 4'h8,
        NSLP_ER_PSIG  = 4'h9, NSLP_WR_FUSE  = 4'ha, NSLP_RD_FUSE  = 4'hb,
        NSLP_WR_LOCK  = 4'hc, NSLP_RD_LOCK  = 4'hd
    } nslp_cmd_e;
    typedef enum logic [1:0] {
        NSLP_MEM_RD = 2'h0, NSLP_MEM_WR = 2'h1, NSLP_MEM_ERPG = 2'h2, NSLP_MEM_ERALL = 2'h3
    } nslp_op_e;
    typedef enum logic [1:0] {
        NSLP_SP_FLASH = 2'h0, NSLP_SP_USIG = 2'h1, NSLP_SP_PSIG = 2'h2
    } nslp_space_e;
    typedef struct packed {
        nslp_cmd_e   cmd;
        logic [23:0] addr;
        logic [15:0] data;
    } nslp_cmd_s;
    typedef struct packed {
        logic        valid;
        nslp_op_e    op;
        nslp_space_e space;
        logic [23:0] addr;
        logic [15:0] wdata;
    } nslp_mem_s;
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } nslp_axi_req_s;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } nslp_axi_rsp_s;
endpackage : nslp_pkg

// File: core/nslp_core.sv
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module nslp_core (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire nslp_pkg::nslp_axi_req_s axi_i,
    output nslp_pkg::nslp_axi_rsp_s      axi_o,
    input  wire logic [15:0]             cpu_pc,
    input  wire logic                    prog_cmd_valid,
    input  wire nslp_pkg::nslp_cmd_s     prog_cmd,
    output logic                         prog_cmd_ready,
    output logic [15:0]                  prog_rdata,
    output logic                         prog_rvalid,
    output nslp_pkg::nslp_mem_s          mem_o,
    input  wire logic                    mem_ready,
    input  wire logic                    mem_rvalid,
    input  wire logic [15:0]             mem_rdata,
    output logic [31:0]                  cal_o,
    output logic                         cal_done,
    output logic [31:0]                  fuse_o,
    output logic [7:0]                   lock_o,
    input  wire logic [23:0]             ds_addr,
    output logic [2:0]                   ds_region
);
    typedef enum logic [5:0] {
        S_CALIB = 6'h01, S_IDLE = 6'h02, S_ISSUE = 6'h04,
        S_WAIT  = 6'h08, S_CE_FL = 6'h10, S_CE_LK = 6'h20
    } nslp_state_e;

    // Word address falls in the boot section
    function automatic logic in_boot(input logic [15:0] a);
        return a >= nslp_pkg::BOOT_START;
    endfunction : in_boot

    // Two-bit lock field governing a flash word address
    function automatic logic [1:0] lock_field(input logic [15:0] a, input logic [7:0] lk);
        if (in_boot(a))
            return lk[nslp_pkg::LK_BOOT_LSB +: 2];
        else if (a >= nslp_pkg::TABLE_START)
            return lk[nslp_pkg::LK_TBL_LSB +: 2];
        else
            return lk[nslp_pkg::LK_APP_LSB +: 2];
    endfunction : lock_field

    // Access policy per command and source
    function automatic logic permit(input nslp_pkg::nslp_cmd_e c, input logic [15:0] a,
                                    input logic from_prog, input logic boot_fetch,
                                    input logic [7:0] lk);
        logic [1:0] f;
        f = lock_field(a, lk);                                         // R4 R5
        case (c)
            nslp_pkg::NSLP_RD_FLASH: return f[nslp_pkg::LK_RD_BIT];
            nslp_pkg::NSLP_WR_FLASH,
            nslp_pkg::NSLP_ER_PAGE:  return f[nslp_pkg::LK_WR_BIT] && (from_prog || boot_fetch);
            nslp_pkg::NSLP_CHIP_ER,
            nslp_pkg::NSLP_WR_FUSE:  return from_prog;                // R9
            nslp_pkg::NSLP_WR_PSIG,
            nslp_pkg::NSLP_ER_PSIG:  return 1'b0;                     // R10
            default:                 return 1'b1;
        endcase
    endfunction : permit

    // Byte-lane merge for register writes
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i])
                r[8*i +: 8] = d[8*i +: 8];
        end
        return r;
    endfunction : wmerge

    nslp_state_e            state_q, state_d;
    nslp_pkg::nslp_cmd_s    cpu_q, cpu_d, cur_q, cur_d, sel;
    logic                   pend_q, pend_d, src_q, src_d, deny_q, deny_d;
    logic [7:0]             lock_q, lock_d;
    logic [31:0]            fuse_q, fuse_d, cal_q, cal_d;
    logic [15:0]            rd_q, rd_d, prd_q, prd_d;
    logic                   prv_q, prv_d, cdone_q, cdone_d, cwait_q, cwait_d;
    logic [$clog2(nslp_pkg::CAL_AUTO)-1:0] cidx_q, cidx_d;
    logic                   bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]             bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]            rdata_q, rdata_d;
    logic [2:0]             dsr_q, dsr_d;
    logic                   wacc, racc, take_prog, take_cpu, ok, deny_evt;
    logic [1:0]             cpu_field;

    assign wacc = axi_i.awvalid && axi_i.wvalid && !bvalid_q;
    assign racc = axi_i.arvalid && !rvalid_q;
    // Programmer wins over a pending software command
    assign take_prog = (state_q == S_IDLE) && prog_cmd_valid;                  // R14
    assign take_cpu  = (state_q == S_IDLE) && !prog_cmd_valid && pend_q;       // R14
    assign sel       = take_prog ? prog_cmd : cpu_q;
    assign ok        = permit(sel.cmd, sel.addr[15:0], take_prog, in_boot(cpu_pc), lock_q);
    // Denial this cycle, so a software clear cannot hide it even when already set
    assign deny_evt  = (take_prog || take_cpu) && !ok;                         // R17
    assign cpu_field = lock_field(cpu_q.addr[15:0], lock_q);                   // R4

    // Bus answers, registered so payload is stable until taken
    always_comb begin
        axi_o.awready = wacc;
        axi_o.wready  = wacc;
        axi_o.bvalid  = bvalid_q;
        axi_o.bresp   = bresp_q;
        axi_o.arready = racc;
        axi_o.rvalid  = rvalid_q;
        axi_o.rdata   = rdata_q;
        axi_o.rresp   = rresp_q;
    end

    // Memory request is driven from held command flops only
    always_comb begin
        mem_o.valid = 1'b0;
        mem_o.op    = nslp_pkg::NSLP_MEM_RD;
        mem_o.space = nslp_pkg::NSLP_SP_FLASH;
        mem_o.addr  = cur_q.addr;
        mem_o.wdata = cur_q.data;
        case (state_q)
            S_CALIB: begin
                mem_o.valid = !cwait_q;
                mem_o.space = nslp_pkg::NSLP_SP_PSIG;                          // R11
                mem_o.addr  = 24'(cidx_q);
            end
            S_ISSUE: begin
                mem_o.valid = 1'b1;
                case (cur_q.cmd)
                    nslp_pkg::NSLP_WR_FLASH: mem_o.op = nslp_pkg::NSLP_MEM_WR;
                    nslp_pkg::NSLP_ER_PAGE:  mem_o.op = nslp_pkg::NSLP_MEM_ERPG;
                    nslp_pkg::NSLP_RD_USIG:  mem_o.space = nslp_pkg::NSLP_SP_USIG;
                    nslp_pkg::NSLP_RD_PSIG:  mem_o.space = nslp_pkg::NSLP_SP_PSIG;
                    nslp_pkg::NSLP_WR_USIG: begin
                        mem_o.op    = nslp_pkg::NSLP_MEM_WR;
                        mem_o.space = nslp_pkg::NSLP_SP_USIG;
                    end
                    nslp_pkg::NSLP_ER_USIG: begin                              // R12
                        mem_o.op    = nslp_pkg::NSLP_MEM_ERPG;
                        mem_o.space = nslp_pkg::NSLP_SP_USIG;
                    end
                    default: mem_o.op = nslp_pkg::NSLP_MEM_RD;
                endcase
            end
            S_CE_FL: begin
                // Flash space only, so the user row survives
                mem_o.valid = 1'b1;
                mem_o.op    = nslp_pkg::NSLP_MEM_ERALL;                        // R12
            end
            default: mem_o.valid = 1'b0;
        endcase
    end

    // Next state of control, policy stores and register file
    always_comb begin
        state_d  = state_q;
        cpu_d    = cpu_q;
        cur_d    = cur_q;
        pend_d   = pend_q;
        src_d    = src_q;
        deny_d   = deny_q;
        lock_d   = lock_q;
        fuse_d   = fuse_q;
        cal_d    = cal_q;
        rd_d     = rd_q;
        prd_d    = prd_q;
        prv_d    = 1'b0;
        cdone_d  = cdone_q;
        cwait_d  = cwait_q;
        cidx_d   = cidx_q;
        bvalid_d = bvalid_q && !axi_i.bready;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q && !axi_i.rready;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        case (state_q)
            S_CALIB: begin
                if (!cwait_q && mem_ready)
                    cwait_d = 1'b1;
                if (cwait_q && mem_rvalid) begin
                    cal_d[16*cidx_q +: 16] = mem_rdata;                        // R11
                    cwait_d = 1'b0;
                    cidx_d  = cidx_q + 1'b1;
                    if (32'(cidx_q) == nslp_pkg::CAL_AUTO - 1) begin
                        cdone_d = 1'b1;
                        state_d = S_IDLE;
                    end
                end
            end
            S_IDLE: begin
                if (take_prog || take_cpu) begin
                    pend_d = take_prog ? pend_q : 1'b0;
                    src_d  = take_prog;
                    cur_d  = sel;
                    if (!ok) begin
                        deny_d = 1'b1;                                         // R17
                    end else begin
                        case (sel.cmd)
                            nslp_pkg::NSLP_WR_LOCK: lock_d = lock_q & sel.data[7:0]; // R6
                            nslp_pkg::NSLP_WR_FUSE:
                                fuse_d[8*sel.addr[1:0] +: 8] = sel.data[7:0];  // R9
                            nslp_pkg::NSLP_RD_FUSE: begin
                                prd_d = {8'h00, fuse_q[8*sel.addr[1:0] +: 8]};
                                prv_d = take_prog;
                            end
                            nslp_pkg::NSLP_RD_LOCK: begin
                                prd_d = {8'h00, lock_q};                       // R8
                                prv_d = take_prog;
                            end
                            nslp_pkg::NSLP_CHIP_ER: state_d = S_CE_FL;
                            default: state_d = S_ISSUE;                        // R1 R2
                        endcase
                    end
                end
            end
            S_ISSUE: begin
                if (mem_ready)
                    state_d = (cur_q.cmd == nslp_pkg::NSLP_RD_FLASH ||
                               cur_q.cmd == nslp_pkg::NSLP_RD_USIG ||
                               cur_q.cmd == nslp_pkg::NSLP_RD_PSIG) ? S_WAIT : S_IDLE;
            end
            S_WAIT: begin
                if (mem_rvalid) begin
                    state_d = S_IDLE;
                    if (src_q) begin
                        prd_d = mem_rdata;                                     // R3
                        prv_d = 1'b1;
                    end else begin
                        rd_d = mem_rdata;                                      // R3
                    end
                end
            end
            S_CE_FL: begin
                if (mem_ready)
                    state_d = S_CE_LK;                                         // R7
            end
            S_CE_LK: begin
                lock_d  = nslp_pkg::LOCK_RST;                                  // R7
                state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
        // Register writes; a clear of the deny flag loses to a new denial
        if (wacc) begin
            bvalid_d = 1'b1;
            bresp_d  = nslp_pkg::RESP_OKAY;
            case (axi_i.awaddr)
                nslp_pkg::REG_ADDR:
                    cpu_d.addr = 24'(wmerge({8'h00, cpu_q.addr}, axi_i.wdata, axi_i.wstrb));
                nslp_pkg::REG_DATA:
                    cpu_d.data = 16'(wmerge({16'h0000, cpu_q.data}, axi_i.wdata, axi_i.wstrb));
                nslp_pkg::REG_CMD: begin
                    if ((!pend_q || take_cpu) && axi_i.wstrb[0]) begin
                        cpu_d.cmd = nslp_pkg::nslp_cmd_e'(axi_i.wdata[3:0]);
                        pend_d    = 1'b1;
                    end
                end
                nslp_pkg::REG_STATUS: begin
                    if (axi_i.wstrb[0] && axi_i.wdata[nslp_pkg::ST_DENY] && !deny_evt)
                        deny_d = 1'b0;
                end
                nslp_pkg::REG_LOCK: begin
                    if (axi_i.wstrb[0])
                        lock_d = lock_d & axi_i.wdata[7:0];                    // R6
                end
                nslp_pkg::REG_FUSE: deny_d = 1'b1;                             // R9
                default: bresp_d = nslp_pkg::RESP_SLVERR;
            endcase
        end
        // Register reads
        if (racc) begin
            rvalid_d = 1'b1;
            rresp_d  = nslp_pkg::RESP_OKAY;
            case (axi_i.araddr)
                nslp_pkg::REG_ADDR:   rdata_d = {8'h00, cpu_q.addr};
                nslp_pkg::REG_DATA:   rdata_d = {16'h0000, rd_q};
                nslp_pkg::REG_CMD:    rdata_d = {28'h0000000, cpu_q.cmd};
                nslp_pkg::REG_STATUS: rdata_d = {29'h0, pend_q, deny_q,
                                                 state_q != S_IDLE};
                nslp_pkg::REG_LOCK:   rdata_d = {24'h000000, lock_q};          // R8
                nslp_pkg::REG_FUSE:   rdata_d = fuse_q;                        // R9
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = nslp_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // Fixed data-space map: one-hot {sram, eeprom, io}
    always_comb begin
        if (ds_addr >= nslp_pkg::DS_SRAM_BASE)
            dsr_d = 3'h4;                                                      // R16
        else if (ds_addr >= nslp_pkg::DS_EEP_BASE)
            dsr_d = 3'h2;                                                      // R15
        else
            dsr_d = 3'h1;                                                      // R15
    end

    // Registers; fuses and locks come up erased since storage sits outside
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q  <= S_CALIB;
            cpu_q    <= '{cmd: nslp_pkg::NSLP_RD_FLASH, addr: 24'h000000, data: 16'h0000};
            cur_q    <= '{cmd: nslp_pkg::NSLP_RD_FLASH, addr: 24'h000000, data: 16'h0000};
            pend_q   <= 1'b0;
            src_q    <= 1'b0;
            deny_q   <= 1'b0;
            lock_q   <= nslp_pkg::LOCK_RST;
            fuse_q   <= {nslp_pkg::FUSE_BYTES{nslp_pkg::FUSE_RST}};
            cal_q    <= 32'h00000000;
            rd_q     <= 16'h0000;
            prd_q    <= 16'h0000;
            prv_q    <= 1'b0;
            cdone_q  <= 1'b0;
            cwait_q  <= 1'b0;
            cidx_q   <= '0;
            bvalid_q <= 1'b0;
            bresp_q  <= nslp_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q  <= nslp_pkg::RESP_OKAY;
            rdata_q  <= 32'h00000000;
            dsr_q    <= 3'h1;
        end else begin
            state_q  <= state_d;
            cpu_q    <= cpu_d;
            cur_q    <= cur_d;
            pend_q   <= pend_d;
            src_q    <= src_d;
            deny_q   <= deny_d;
            lock_q   <= lock_d;
            fuse_q   <= fuse_d;
            cal_q    <= cal_d;
            rd_q     <= rd_d;
            prd_q    <= prd_d;
            prv_q    <= prv_d;
            cdone_q  <= cdone_d;
            cwait_q  <= cwait_d;
            cidx_q   <= cidx_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q  <= rresp_d;
            rdata_q  <= rdata_d;
            dsr_q    <= dsr_d;
        end
    end

    assign prog_cmd_ready = state_q == S_IDLE;
    assign prog_rdata     = prd_q;
    assign prog_rvalid    = prv_q;
    assign cal_o          = cal_q;
    assign cal_done       = cdone_q;
    assign fuse_o         = fuse_q;
    assign lock_o         = lock_q;
    assign ds_region      = dsr_q;

    property p_app_no_write;
        @(posedge aclk) disable iff (!aresetn)
        take_cpu && cpu_q.cmd == nslp_pkg::NSLP_WR_FLASH && !in_boot(cpu_pc)
            |=> state_q == S_IDLE ##1 !(mem_o.valid && mem_o.op == nslp_pkg::NSLP_MEM_WR);
    endproperty
    a_app_no_write: assert property (p_app_no_write) else $error("app write started"); // R1

    property p_boot_write_any;
        @(posedge aclk) disable iff (!aresetn)
        take_cpu && cpu_q.cmd == nslp_pkg::NSLP_WR_FLASH && in_boot(cpu_pc)
            && cpu_field[nslp_pkg::LK_WR_BIT]
            |=> mem_o.valid && mem_o.op == nslp_pkg::NSLP_MEM_WR && mem_o.addr == $past(cpu_q.addr);
    endproperty
    a_boot_write_any: assert property (p_boot_write_any) else $error("boot write lost"); // R2

    property p_lock_stricter;
        @(posedge aclk) disable iff (!aresetn)
        state_q != S_CE_LK |=> (lock_q & ~$past(lock_q)) == 8'h00;
    endproperty
    a_lock_stricter: assert property (p_lock_stricter) else $error("lock loosened"); // R6

    property p_lock_after_erase;
        @(posedge aclk) disable iff (!aresetn)
        state_q == S_CE_FL && mem_ready |=> state_q == S_CE_LK ##1 lock_q == nslp_pkg::LOCK_RST;
    endproperty
    a_lock_after_erase: assert property (p_lock_after_erase) else $error("lock clear order"); // R7

    property p_fuse_prog_only;
        @(posedge aclk) disable iff (!aresetn)
        $changed(fuse_q) |-> $past(take_prog);
    endproperty
    a_fuse_prog_only: assert property (p_fuse_prog_only) else $error("fuse changed by cpu"); // R9

    property p_psig_read_only;
        @(posedge aclk) disable iff (!aresetn)
        mem_o.valid && mem_o.space == nslp_pkg::NSLP_SP_PSIG |-> mem_o.op == nslp_pkg::NSLP_MEM_RD;
    endproperty
    a_psig_read_only: assert property (p_psig_read_only) else $error("psig modified"); // R10

    property p_usig_kept;
        @(posedge aclk) disable iff (!aresetn)
        mem_o.valid && mem_o.op == nslp_pkg::NSLP_MEM_ERALL |-> mem_o.space == nslp_pkg::NSLP_SP_FLASH;
    endproperty
    a_usig_kept: assert property (p_usig_kept) else $error("chip erase hit user row"); // R12

    property p_deny_silent;
        @(posedge aclk) disable iff (!aresetn)
        (take_prog || take_cpu) && !ok |=> state_q == S_IDLE && deny_q && !prog_rvalid;
    endproperty
    a_deny_silent: assert property (p_deny_silent) else $error("denied access acted"); // R17

    property p_sram_map;
        @(posedge aclk) disable iff (!aresetn)
        ds_addr >= nslp_pkg::DS_SRAM_BASE |=> ds_region == 3'h4;
    endproperty
    a_sram_map: assert property (p_sram_map) else $error("sram base wrong"); // R16
endmodule : nslp_core
`default_nettype wire

// File: test/nslp_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nslp_core_tb;
    logic aclk, aresetn, pv, prdy, prv, mr, mrv, cd;
    logic [15:0] prd, mrd, pcv;
    logic [31:0] cal, fuse, rd;
    logic [7:0] lk;
    logic [23:0] dsa;
    logic [2:0] dsr;
    logic [1:0] rs;
    int bad_count, check_count;
    nslp_pkg::nslp_axi_req_s ai;
    nslp_pkg::nslp_axi_rsp_s ao;
    nslp_pkg::nslp_cmd_s pc;
    nslp_pkg::nslp_mem_s mo;
    logic [26:0] rows [4] = '{{24'h000fff, 3'h1}, {24'h001000, 3'h2},
                              {24'h001fff, 3'h2}, {24'h002000, 3'h4}};
    nslp_core dut (.aclk(aclk), .aresetn(aresetn), .axi_i(ai), .axi_o(ao), .cpu_pc(pcv),
        .prog_cmd_valid(pv), .prog_cmd(pc), .prog_cmd_ready(prdy), .prog_rdata(prd),
        .prog_rvalid(prv), .mem_o(mo), .mem_ready(mr), .mem_rvalid(mrv), .mem_rdata(mrd),
        .cal_o(cal), .cal_done(cd), .fuse_o(fuse), .lock_o(lk), .ds_addr(dsa), .ds_region(dsr));
    nslp_flash_model u_mem (.aclk(aclk), .mem_o(mo), .mem_ready(mr), .mem_rvalid(mrv),
        .mem_rdata(mrd));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask : cmp
    // Hold address and data until the address handshake, bready until bvalid; all lanes enabled
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        ai.awaddr <= a;
        ai.wdata <= d;
        ai.wstrb <= 4'hf;
        ai.awvalid <= 1'b1;
        ai.wvalid <= 1'b1;
        ai.bready <= 1'b1;
        do @(posedge aclk); while (!ao.awready);
        ai.awvalid <= 1'b0;
        ai.wvalid <= 1'b0;
        do @(posedge aclk); while (!ao.bvalid);
        ai.bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        ai.araddr <= a;
        ai.arvalid <= 1'b1;
        ai.rready <= 1'b1;
        do @(posedge aclk); while (!ao.arready);
        ai.arvalid <= 1'b0;
        do @(posedge aclk); while (!ao.rvalid);
        rd = ao.rdata;
        rs = ao.rresp;
        ai.rready <= 1'b0;
    endtask : axr
    // Programmer request held until the idle controller takes it
    task automatic prog(input nslp_pkg::nslp_cmd_s c);
        @(posedge aclk);
        pc <= c;
        pv <= 1'b1;
        do @(posedge aclk); while (!prdy);
        pv <= 1'b0;
    endtask : prog
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    initial begin
        aclk = 0;
        forever #10 aclk = ~aclk;
    end
    // Whole run is well under two hundred cycles
    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        test_done;
    end
    initial begin
        aresetn = 0; ai = '0; pv = 0; pc = '0; dsa = 24'h000000; pcv = 16'h0000;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk); cmp(fuse, 32'hffffffff); cmp({24'h0, lk}, 32'hff);
        wait (cd === 1'b1); @(negedge aclk); cmp(cal, 32'h00050001);
        $display("reset test done");
        foreach (rows[i]) begin
            @(posedge aclk); dsa <= rows[i][26:3];
            repeat (2) @(negedge aclk); cmp({29'h0, dsr}, {29'h0, rows[i][2:0]});
        end
        $display("region test done");
        axw(nslp_pkg::REG_LOCK, 32'hfe); axw(nslp_pkg::REG_LOCK, 32'hff);
        axr(nslp_pkg::REG_LOCK); cmp(rd, 32'hfe); cmp({24'h0, lk}, 32'hfe);
        axw(nslp_pkg::REG_FUSE, 32'h0); axr(nslp_pkg::REG_STATUS);
        cmp(rd & 32'h2, 32'h2); cmp(fuse, 32'hffffffff);
        axr(8'h40); cmp({30'h0, rs}, {30'h0, nslp_pkg::RESP_SLVERR});
        $display("register test done");
        prog('{nslp_pkg::NSLP_CHIP_ER, 24'h0, 16'h0});
        repeat (8) @(negedge aclk);
        cmp({24'h0, lk}, 32'hff);
        // Every fuse byte gets a programmed value, never left erased
        for (int i = 0; i < 4; i++) prog('{nslp_pkg::NSLP_WR_FUSE, 24'(i), 16'h5a});
        repeat (2) @(negedge aclk);
        cmp(fuse, 32'h5a5a5a5a);
        prog('{nslp_pkg::NSLP_RD_FLASH, 24'h000123, 16'h0});
        do @(posedge aclk); while (!prv);
        cmp({16'h0, prd}, 32'h48d);
        $display("erase and programmer test done");
        pcv <= 16'h0100;
        axw(nslp_pkg::REG_STATUS, 32'h2);
        axw(nslp_pkg::REG_ADDR, 32'hf010);
        axw(nslp_pkg::REG_CMD, 32'h1);
        repeat (4) @(posedge aclk);
        axr(nslp_pkg::REG_STATUS);
        cmp(rd, 32'h2);
        pcv <= 16'hf000;
        axw(nslp_pkg::REG_STATUS, 32'h2);
        axw(nslp_pkg::REG_CMD, 32'h1);
        repeat (4) @(posedge aclk);
        axr(nslp_pkg::REG_STATUS);
        cmp(rd, 32'h0);
        axw(nslp_pkg::REG_ADDR, 32'h40);
        axw(nslp_pkg::REG_CMD, 32'h0);
        repeat (6) @(posedge aclk);
        axr(nslp_pkg::REG_DATA);
        cmp(rd, 32'h101);
        $display("software test done");
        test_done;
    end
endmodule : nslp_core_tb
`default_nettype wire

// File: test/nslp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module nslp_flash_model (
    input  wire logic                aclk,
    input  wire nslp_pkg::nslp_mem_s mem_o,
    output logic                     mem_ready,
    output logic                     mem_rvalid,
    output logic [15:0]              mem_rdata
);
    initial begin
        mem_ready = 1'b0;
        mem_rvalid = 1'b0;
        mem_rdata = 16'h0000;
    end
    // Take each request one cycle late; the slow answer stresses the hold
    always @(posedge aclk) begin
        mem_ready  <= mem_o.valid & !mem_ready;
        mem_rvalid <= mem_o.valid & mem_ready & (mem_o.op == nslp_pkg::NSLP_MEM_RD);
        // Word is 16 bits; outside a beat the bus shows a changing pattern
        mem_rdata  <= (mem_o.valid & mem_ready) ? {mem_o.addr[13:0], 2'h1} : ~mem_rdata;
    end
endmodule : nslp_flash_model
`default_nettype wire
